// file: nvtr_pkg.sv
/*
 * nvtr_pkg: constants, carrier types and BCD helpers for the timekeeping ram.
 * Assumes a 10 MHz reference clock; the clock byte locations sit at the top
 * of a 2k x 8 byte space.
 */
`default_nettype none
package nvtr_pkg;

    // port geometry
    localparam int ADDR_W = 11;
    localparam int DATA_W = 8;
    localparam int MEM_DEPTH = 2048;

    // clock byte locations, lowest to highest
    localparam logic [10:0] ADDR_CENT  = 11'h7f8;
    localparam logic [2:0]  IDX_CENT   = 3'h0;
    localparam logic [2:0]  IDX_SEC    = 3'h1;
    localparam logic [2:0]  IDX_MIN    = 3'h2;
    localparam logic [2:0]  IDX_HOUR   = 3'h3;
    localparam logic [2:0]  IDX_DAY    = 3'h4;
    localparam logic [2:0]  IDX_DATE   = 3'h5;
    localparam logic [2:0]  IDX_MONTH  = 3'h6;
    localparam logic [2:0]  IDX_YEAR   = 3'h7;

    // control bit positions
    localparam int CTL_SET_BIT    = 7;
    localparam int CTL_FREEZE_BIT = 6;
    localparam int SEC_HALT_BIT   = 7;
    localparam int DAY_HEALTH_BIT = 7;
    localparam int DAY_TONE_BIT   = 6;
    localparam int SEC_LSB_BIT    = 0;

    // used-bit masks; unused bits store and read as zero
    localparam logic [7:0] CENT_MASK  = 8'h3f;
    localparam logic [7:0] SEC_MASK   = 8'h7f;
    localparam logic [7:0] MIN_MASK   = 8'h7f;
    localparam logic [7:0] HOUR_MASK  = 8'h3f;
    localparam logic [7:0] DAY_MASK   = 8'h07;
    localparam logic [7:0] DATE_MASK  = 8'h3f;
    localparam logic [7:0] MONTH_MASK = 8'h1f;
    localparam logic [7:0] YEAR_MASK  = 8'hff;

    // bcd limits
    localparam logic [7:0] BCD_ZERO   = 8'h00;
    localparam logic [7:0] BCD_ONE    = 8'h01;
    localparam logic [3:0] BCD_NINE   = 4'h9;
    localparam logic [7:0] SEC_LAST   = 8'h59;
    localparam logic [7:0] HOUR_LAST  = 8'h23;
    localparam logic [7:0] DAY_LAST   = 8'h07;
    localparam logic [7:0] MONTH_LAST = 8'h12;
    localparam logic [7:0] YEAR_LAST  = 8'h99;
    localparam logic [7:0] CENT_LAST  = 8'h39;
    localparam logic [7:0] FEB        = 8'h02;
    localparam logic [7:0] APR        = 8'h04;
    localparam logic [7:0] JUN        = 8'h06;
    localparam logic [7:0] SEP        = 8'h09;
    localparam logic [7:0] NOV        = 8'h11;
    localparam logic [7:0] DAYS_28    = 8'h28;
    localparam logic [7:0] DAYS_29    = 8'h29;
    localparam logic [7:0] DAYS_30    = 8'h30;
    localparam logic [7:0] DAYS_31    = 8'h31;

    // timing: a 1024 Hz tick makes the 512 Hz tone and, counted, the second
    localparam int CLK_HZ       = 10_000_000;
    localparam int TONE_HZ      = 512;
    localparam int TICK_HZ      = 2 * TONE_HZ;
    localparam int TICK_CYC     = CLK_HZ / TICK_HZ;
    localparam int DIV_W        = 14;
    localparam int SUB_W        = 10;
    localparam logic [SUB_W-1:0] SUB_LAST = SUB_W'(TICK_HZ - 1);

    // time carrier, all fields bcd
    typedef struct packed {
        logic [7:0] cent;
        logic [7:0] year;
        logic [7:0] month;
        logic [7:0] date;
        logic [7:0] day;
        logic [7:0] hour;
        logic [7:0] min;
        logic [7:0] sec;
    } nvtr_time_t;

    // control bits held beside the host-visible copy
    typedef struct packed {
        logic set_mode;
        logic freeze;
        logic crystal_halt;
        logic test_tone_enable;
    } nvtr_ctl_t;

    localparam nvtr_time_t TIME_RST = '{cent: BCD_ZERO, year: BCD_ZERO,
        month: BCD_ONE, date: BCD_ONE, day: BCD_ONE, hour: BCD_ZERO,
        min: BCD_ZERO, sec: BCD_ZERO};
    localparam nvtr_ctl_t CTL_RST = '0;

    // bcd increment with wrap; bit 8 is the carry out
    function automatic logic [8:0] nvtr_bcd_inc(input logic [7:0] v,
                                                input logic [7:0] last,
                                                input logic [7:0] first);
        logic [8:0] r;
        if (v == last) begin
            r = {1'b1, first};
        end else if (v[3:0] == BCD_NINE) begin
            r = {1'b0, v[7:4] + 4'h1, 4'h0};
        end else begin
            r = {1'b0, v[7:4], v[3:0] + 4'h1};
        end
        return r;
    endfunction

    // last date of a month; year 00 counts as leap
    function automatic logic [7:0] nvtr_month_last(input logic [7:0] month,
                                                   input logic [7:0] year);
        logic leap;
        leap = year[4] ? (year[3:0] == 4'h2 || year[3:0] == 4'h6)
                       : (year[3:0] == 4'h0 || year[3:0] == 4'h4 ||
                          year[3:0] == 4'h8);
        if (month == FEB) begin
            return leap ? DAYS_29 : DAYS_28;
        end else if (month == APR || month == JUN || month == SEP ||
                     month == NOV) begin
            return DAYS_30;
        end
        return DAYS_31;
    endfunction

endpackage
`default_nettype wire

// file: nvtr_ram.sv
/*
 * nvtr_ram: plain 2k x 8 byte store with a registered read port.
 * Assumes the caller gates writes (power fail, clock locations) itself.
 */
`timescale 1ns/1ps
`default_nettype none
module nvtr_ram
    import nvtr_pkg::*;
(
    // clock, reset, enable
    input  wire logic              ref_clk_in,
    input  wire logic              rst_n_in,
    input  wire logic              clk_en_in,
    // access
    input  wire logic              wr_en_in,
    input  wire logic [ADDR_W-1:0] addr_in,
    input  wire logic [DATA_W-1:0] wdata_in,
    output logic      [DATA_W-1:0] rdata_out
);
    logic [DATA_W-1:0] mem [MEM_DEPTH];
    logic [DATA_W-1:0] rdata_q;
    logic [DATA_W-1:0] rdata_d;

    // storage keeps no reset value, as a real array would not
    always_ff @(posedge ref_clk_in) begin
        if (clk_en_in && wr_en_in) begin
            mem[addr_in] <= wdata_in;
        end
    end

    // read register follows the address every cycle
    always_comb begin
        rdata_d = mem[addr_in];
    end

    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rdata_q <= '0;
        end else if (clk_en_in) begin
            rdata_q <= rdata_d;
        end
    end

    assign rdata_out = rdata_q;
endmodule // nvtr_ram
`default_nettype wire

// file: nvtr_rtc.sv
/*
 * nvtr_rtc: real-time clock and calendar inside a 2k x 8 byte memory port.
 * Assumes port pins synchronous to ref_clk_in and a host that keeps
 * address stable during a write.
 */
`timescale 1ns/1ps
`default_nettype none
module nvtr_rtc
    import nvtr_pkg::*;
#(
    parameter int TICK_CYC_P = TICK_CYC
) (
    // clock, reset, enable
    input  wire logic              ref_clk_in,
    input  wire logic              rst_n_in,
    input  wire logic              clk_en_in,
    // byte memory port
    input  wire logic [ADDR_W-1:0] addr_in,
    input  wire logic [DATA_W-1:0] data_in,
    output logic      [DATA_W-1:0] data_out,
    output logic                   data_oe_out,
    input  wire logic              chip_sel_n_in,
    input  wire logic              out_drive_n_in,
    input  wire logic              store_n_in,
    // supply and cell monitors
    input  wire logic              supply_fail_threshold_in,
    input  wire logic              cell_health_flag_in
);
    // internal counters, host copy, controls
    nvtr_time_t cnt_q;
    nvtr_time_t cnt_d;
    nvtr_time_t copy_q;
    nvtr_time_t copy_d;
    nvtr_ctl_t  ctl_q;
    nvtr_ctl_t  ctl_d;

    // divider state
    logic [DIV_W-1:0] div_q;
    logic [DIV_W-1:0] div_d;
    logic [SUB_W-1:0] sub_q;
    logic [SUB_W-1:0] sub_d;
    logic             tone_q;
    logic             tone_d;
    logic             tick;
    logic             sec_tick;

    // read path
    logic [7:0]       rd_clk_q;
    logic [7:0]       rd_clk_d;
    logic             sel_clk_q;
    logic             sel_clk_d;
    logic [7:0]       ram_rdata;

    // port decode
    logic             acc_ok;
    logic             wr_act;
    logic             rd_act;
    logic             is_clk;
    logic             set_load;
    logic [2:0]       idx;

    // a clock location is any of the top eight addresses
    function automatic logic clk_addr(input logic [ADDR_W-1:0] a);
        return a[ADDR_W-1:3] == ADDR_CENT[ADDR_W-1:3];
    endfunction

    // power fail outranks every strobe
    always_comb begin
        acc_ok = !supply_fail_threshold_in && !chip_sel_n_in;
        wr_act = acc_ok && !store_n_in;
        rd_act = acc_ok && !out_drive_n_in && store_n_in;
        is_clk = clk_addr(addr_in);
        idx    = addr_in[2:0];
    end

    // ordinary bytes live in the array; clock locations never reach it
    nvtr_ram u_ram (
        .ref_clk_in (ref_clk_in),
        .rst_n_in   (rst_n_in),
        .clk_en_in  (clk_en_in),
        .wr_en_in   (wr_act && !is_clk),
        .addr_in    (addr_in),
        .wdata_in   (data_in),
        .rdata_out  (ram_rdata)
    );

    // 1024 Hz tick from the reference clock; a halted crystal stops it all
    always_comb begin
        div_d  = div_q;
        sub_d  = sub_q;
        tone_d = tone_q;
        tick   = 1'b0;
        if (!ctl_q.crystal_halt) begin
            if (div_q == DIV_W'(TICK_CYC_P - 1)) begin
                div_d  = '0;
                tick   = 1'b1;
                tone_d = !tone_q;
            end else begin
                div_d = div_q + DIV_W'(1);
            end
            if (tick) begin
                sub_d = (sub_q == SUB_LAST) ? '0 : sub_q + SUB_W'(1);
            end
        end
        sec_tick = tick && (sub_q == SUB_LAST);
    end

    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            div_q  <= '0;
            sub_q  <= '0;
            tone_q <= 1'b0;
        end else if (clk_en_in) begin
            div_q  <= div_d;
            sub_q  <= sub_d;
            tone_q <= tone_d;
        end
    end

    // host copy and controls; refresh runs every cycle unless set or frozen,
    // so a freeze captures the time current at the request
    always_comb begin
        copy_d = copy_q;
        ctl_d  = ctl_q;
        if (!ctl_q.set_mode && !ctl_q.freeze) begin
            copy_d = cnt_q;
        end
        if (wr_act && is_clk) begin
            unique case (idx)
                IDX_CENT: begin
                    copy_d.cent    = data_in & CENT_MASK;
                    ctl_d.set_mode = data_in[CTL_SET_BIT];
                    ctl_d.freeze   = data_in[CTL_FREEZE_BIT];
                end
                IDX_SEC: begin
                    copy_d.sec         = data_in & SEC_MASK;
                    ctl_d.crystal_halt = data_in[SEC_HALT_BIT];
                end
                IDX_MIN:   copy_d.min   = data_in & MIN_MASK;
                IDX_HOUR:  copy_d.hour  = data_in & HOUR_MASK;
                IDX_DAY: begin
                    // health bit is not stored: it always reflects the input
                    copy_d.day             = data_in & DAY_MASK;
                    ctl_d.test_tone_enable = data_in[DAY_TONE_BIT];
                end
                IDX_DATE:  copy_d.date  = data_in & DATE_MASK;
                IDX_MONTH: copy_d.month = data_in & MONTH_MASK;
                IDX_YEAR:  copy_d.year  = data_in & YEAR_MASK;
            endcase
        end
        set_load = ctl_q.set_mode && !ctl_d.set_mode;
    end

    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            copy_q <= TIME_RST;
            ctl_q  <= CTL_RST;
        end else if (clk_en_in) begin
            copy_q <= copy_d;
            ctl_q  <= ctl_d;
        end
    end

    // counter chain; a set-time release overrides the second step
    always_comb begin
        logic [8:0] s;
        logic [8:0] m;
        logic [8:0] h;
        logic [8:0] w;
        logic [8:0] dt;
        logic [8:0] mo;
        logic [8:0] y;
        logic [8:0] c;
        cnt_d = cnt_q;
        s  = nvtr_bcd_inc(cnt_q.sec, SEC_LAST, BCD_ZERO);
        m  = nvtr_bcd_inc(cnt_q.min, SEC_LAST, BCD_ZERO);
        h  = nvtr_bcd_inc(cnt_q.hour, HOUR_LAST, BCD_ZERO);
        w  = nvtr_bcd_inc(cnt_q.day, DAY_LAST, BCD_ONE);
        dt = nvtr_bcd_inc(cnt_q.date,
                          nvtr_month_last(cnt_q.month, cnt_q.year),
                          BCD_ONE);
        mo = nvtr_bcd_inc(cnt_q.month, MONTH_LAST, BCD_ONE);
        y  = nvtr_bcd_inc(cnt_q.year, YEAR_LAST, BCD_ZERO);
        c  = nvtr_bcd_inc(cnt_q.cent, CENT_LAST, BCD_ZERO);
        if (set_load) begin
            cnt_d = copy_d;
        end else if (sec_tick) begin
            // each field moves only when every lower field other than day wrapped
            cnt_d.sec = s[7:0];
            if (s[8]) begin
                cnt_d.min = m[7:0];
                if (m[8]) begin
                    cnt_d.hour = h[7:0];
                    if (h[8]) begin
                        cnt_d.day  = w[7:0];
                        cnt_d.date = dt[7:0];
                        if (dt[8]) begin
                            cnt_d.month = mo[7:0];
                            if (mo[8]) begin
                                cnt_d.year = y[7:0];
                                if (y[8]) begin
                                    cnt_d.cent = c[7:0];
                                end
                            end
                        end
                    end
                end
            end
        end
    end

    // counters follow the second tick and take the copy only on a set-mode release
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cnt_q <= TIME_RST;
        end else if (clk_en_in) begin
            cnt_q <= cnt_d;
        end
    end

    // clock byte read value; re-evaluated each cycle so the tone shows
    // live on data line zero while a seconds read is held
    always_comb begin
        rd_clk_d  = '0;
        sel_clk_d = is_clk;
        unique case (idx)
            IDX_CENT: begin
                rd_clk_d                 = copy_q.cent;
                rd_clk_d[CTL_SET_BIT]    = ctl_q.set_mode;
                rd_clk_d[CTL_FREEZE_BIT] = ctl_q.freeze;
            end
            IDX_SEC: begin
                rd_clk_d               = copy_q.sec;
                rd_clk_d[SEC_HALT_BIT] = ctl_q.crystal_halt;
                if (ctl_q.test_tone_enable && !ctl_q.crystal_halt) begin
                    rd_clk_d[SEC_LSB_BIT] = tone_q;
                end
            end
            IDX_MIN:   rd_clk_d = copy_q.min;
            IDX_HOUR:  rd_clk_d = copy_q.hour;
            IDX_DAY: begin
                rd_clk_d                 = copy_q.day;
                rd_clk_d[DAY_HEALTH_BIT] = cell_health_flag_in;
                rd_clk_d[DAY_TONE_BIT]   = ctl_q.test_tone_enable;
            end
            IDX_DATE:  rd_clk_d = copy_q.date;
            IDX_MONTH: rd_clk_d = copy_q.month;
            IDX_YEAR:  rd_clk_d = copy_q.year;
        endcase
    end

    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rd_clk_q  <= '0;
            sel_clk_q <= 1'b0;
        end else if (clk_en_in) begin
            rd_clk_q  <= rd_clk_d;
            sel_clk_q <= sel_clk_d;
        end
    end

    // both sources are registers, so data lags the address by one cycle;
    // the enable is immediate so the lines release at once on power fail
    assign data_out    = sel_clk_q ? rd_clk_q : ram_rdata;
    assign data_oe_out = rd_act;

endmodule // nvtr_rtc
`default_nettype wire

// file: nvtr_rtc_props.sv
/*
 * nvtr_rtc_props: port-level assertions for nvtr_rtc.
 * Assumes it is bound onto nvtr_rtc: one clock, async active-low reset.
 */
`timescale 1ns/1ps
`default_nettype none
module nvtr_rtc_props
    import nvtr_pkg::*;
(
    // clock and reset
    input wire logic              ref_clk_in,
    input wire logic              rst_n_in,
    input wire logic              clk_en_in,
    // byte port
    input wire logic [ADDR_W-1:0] addr_in,
    input wire logic [DATA_W-1:0] data_in,
    input wire logic [DATA_W-1:0] data_out,
    input wire logic              data_oe_out,
    input wire logic              chip_sel_n_in,
    input wire logic              out_drive_n_in,
    input wire logic              store_n_in,
    // monitors
    input wire logic              supply_fail_threshold_in,
    input wire logic              cell_health_flag_in
);
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!rst_n_in);

    // a plain ram write taken at this edge
    sequence s_ram_wr;
        !chip_sel_n_in && !store_n_in && !supply_fail_threshold_in && clk_en_in
            && addr_in < ADDR_CENT;
    endsequence
    // the next edge samples the same address with no store
    sequence s_same_rd;
        store_n_in && clk_en_in && $stable(addr_in);
    endsequence
    // addresses of clock bytes sampled by the read register
    sequence s_rd_at(logic [ADDR_W-1:0] a);
        clk_en_in && addr_in == a;
    endsequence

    a_oe_decode: assert property (
        data_oe_out == (!supply_fail_threshold_in && !chip_sel_n_in
                        && !out_drive_n_in && store_n_in))
        else $error("output enable does not follow the strobes");
    a_fail_released: assert property (
        supply_fail_threshold_in |-> !data_oe_out)
        else $error("data driven during supply fail");
    a_desel_released: assert property (
        chip_sel_n_in |-> !data_oe_out)
        else $error("data driven while deselected");
    a_store_released: assert property (
        !store_n_in |-> !data_oe_out)
        else $error("data driven during a store");
    a_ram_readback: assert property (
        s_ram_wr ##1 s_same_rd |=> data_out == $past(data_in, 2))
        else $error("ram byte not read back");
    a_health_live: assert property (
        s_rd_at(11'h7fc) |=> data_out[DAY_HEALTH_BIT] == $past(cell_health_flag_in))
        else $error("cell flag not shown live");
    a_day_reserved: assert property (
        s_rd_at(11'h7fc) |=> data_out[5:3] == 3'h0)
        else $error("day reserved bits not zero");
    a_sec_bcd: assert property (
        s_rd_at(11'h7f9) |=> data_out[3:0] <= 4'h9 && data_out[6:4] <= 3'h5)
        else $error("seconds not bcd");
    a_hour_range: assert property (
        s_rd_at(11'h7fb) |=> data_out[7:6] == 2'h0 && data_out[5:0] <= 6'h23)
        else $error("hours beyond 23");
    a_month_reserved: assert property (
        s_rd_at(11'h7fe) |=> data_out[7:5] == 3'h0)
        else $error("month reserved bits not zero");
endmodule // nvtr_rtc_props
`default_nettype wire

// file: nvtr_host_model.sv
/*
 * nvtr_host_model: host driving the bytewide port of the timekeeping ram.
 * Assumes the bench resolves the shared data wire and feeds it back here.
 */
`timescale 1ns/1ps
`default_nettype none
module nvtr_host_model
    import nvtr_pkg::*;
(
    // clock
    input  wire logic              ref_clk_in,
    // host side of the byte port
    output logic      [ADDR_W-1:0] addr_out,
    output logic      [DATA_W-1:0] data_out,
    input  wire logic [DATA_W-1:0] data_in,
    input  wire logic              data_oe_in,
    output logic                   chip_sel_n_out,
    output logic                   out_drive_n_out,
    output logic                   store_n_out
);
    // idle port: all strobes high, bus shows a non-data pattern
    initial begin
        addr_out = '0;
        data_out = 8'h55;
        chip_sel_n_out = 1'b1;
        out_drive_n_out = 1'b1;
        store_n_out = 1'b1;
    end

    // select and store low across one sampling edge, address held
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge ref_clk_in);
        #1;
        addr_out = a;
        data_out = d;
        chip_sel_n_out = 1'b0;
        store_n_out = 1'b0;
        @(posedge ref_clk_in);
        #1;
        chip_sel_n_out = 1'b1;
        store_n_out = 1'b1;
        data_out = ~d; // released bus must not keep the last byte
    endtask

    // read held for 1+n edges; counts flips of data line zero meanwhile
    task automatic rd(input logic [ADDR_W-1:0] a, input int n,
                      output logic [DATA_W-1:0] d, output int flips, output logic oe);
        logic [DATA_W-1:0] prev;
        @(posedge ref_clk_in);
        #1;
        addr_out = a;
        chip_sel_n_out = 1'b0;
        out_drive_n_out = 1'b0;
        @(posedge ref_clk_in);
        #1;
        d = data_in;
        oe = data_oe_in;
        prev = data_in;
        flips = 0;
        repeat (n) begin
            @(posedge ref_clk_in);
            #1;
            if (data_in[SEC_LSB_BIT] !== prev[SEC_LSB_BIT]) flips++;
            prev = data_in;
        end
        chip_sel_n_out = 1'b1;
        out_drive_n_out = 1'b1;
    endtask
endmodule // nvtr_host_model
`default_nettype wire

// file: nvtr_rtc_tb_top.sv
/*
 * nvtr_rtc_tb_top: scenario bench for nvtr_rtc driven by nvtr_host_model.
 * Assumes a short tick parameter so one second is 4096 cycles.
 */
`timescale 1ns/1ps
`default_nettype none
module nvtr_rtc_tb_top
    import nvtr_pkg::*;
;
    localparam int TICKS   = 4;
    localparam int SEC_CYC = TICKS * 1024;
    logic              ref_clk, rst_n, sf, health, doe, cs_n, oe_n, st_n;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] hdata, ddata, bus;
    int                err_total = 0;
    int                n_checks = 0;

    // shared data wire: device when enabled, else the host
    assign bus = doe ? ddata : hdata;

    nvtr_rtc #(.TICK_CYC_P(TICKS)) uut (
        .ref_clk_in(ref_clk), .rst_n_in(rst_n), .clk_en_in(1'b1),
        .addr_in(addr), .data_in(bus), .data_out(ddata), .data_oe_out(doe),
        .chip_sel_n_in(cs_n), .out_drive_n_in(oe_n), .store_n_in(st_n),
        .supply_fail_threshold_in(sf), .cell_health_flag_in(health));
    nvtr_host_model host (
        .ref_clk_in(ref_clk), .addr_out(addr), .data_out(hdata), .data_in(bus),
        .data_oe_in(doe), .chip_sel_n_out(cs_n), .out_drive_n_out(oe_n),
        .store_n_out(st_n));

    // free-running 10 MHz clock
    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end

    task automatic end_sim();
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    // range compare; lo equal to hi makes it exact
    task automatic chk(input logic [7:0] g, lo, hi, input string m);
        n_checks++;
        if (^g === 1'bx || g < lo || g > hi) begin
            err_total++;
            $display("FAIL %0t %s got %h want %h..%h", $time, m, g, lo, hi);
        end
    endtask
    task automatic rd(input logic [10:0] a, output logic [7:0] d);
        int  f;
        logic o;
        host.rd(a, 0, d, f, o);
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge ref_clk);
    endtask
    task automatic pin(ref logic s, input logic v);
        @(posedge ref_clk);
        #1;
        s = v;
    endtask

    // reset pulse of two cycles, then the whole clock map
    task automatic t_reset();
        logic [7:0] d;
        logic [7:0] e [8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h81, 8'h01, 8'h01, 8'h00};
        pin(rst_n, 1'b0);
        idle(2);
        #1;
        rst_n = 1'b1;
        for (int i = 0; i < 8; i++) begin
            rd(ADDR_CENT + 11'(i), d);
            chk(d, e[i], e[i], "reset map");
        end
        $display("t_reset done");
    endtask

    // ordinary bytes, including the one just below the clock
    task automatic t_ram();
        logic [7:0] d;
        host.wr(11'h000, 8'ha5);
        host.wr(11'h7f7, 8'h3c);
        rd(11'h000, d);
        chk(d, 8'ha5, 8'ha5, "ram low");
        rd(11'h7f7, d);
        chk(d, 8'h3c, 8'h3c, "ram top");
        $display("t_ram done");
    endtask

    // set 23:59:59 on feb 28, let one second pass, freeze and read
    task automatic t_cal(input logic [7:0] yr, dt, mo);
        logic [7:0] d;
        logic [7:0] v [7] = '{8'h80, 8'h59, 8'h59, 8'h23, 8'h07, 8'h28, 8'h02};
        logic [7:0] e [7] = '{8'h00, 8'h00, 8'h00, 8'h81, dt, mo, yr};
        for (int i = 0; i < 7; i++) host.wr(ADDR_CENT + 11'(i), v[i]);
        host.wr(11'h7ff, yr);
        host.wr(ADDR_CENT, 8'h00);
        idle(SEC_CYC + 8);
        host.wr(ADDR_CENT, 8'h40);
        for (int i = 0; i < 7; i++) begin
            rd(ADDR_CENT + 11'(i + 1), d);
            chk(d, e[i], (i == 0) ? 8'h01 : e[i], "calendar");
        end
        $display("t_cal done");
    endtask

    // copy holds while frozen, counters keep going underneath
    task automatic t_freeze();
        logic [7:0] s0, d;
        rd(11'h7f9, s0);
        idle(2 * SEC_CYC);
        rd(11'h7f9, d);
        chk(d, s0, s0, "frozen copy");
        host.wr(ADDR_CENT, 8'h00);
        rd(11'h7f9, d);
        chk(d, s0 + 8'h02, s0 + 8'h03, "refresh");
        idle(5000);
        $display("t_freeze done");
    endtask

    task automatic t_halt();
        logic [7:0] s1, d;
        host.wr(11'h7f9, 8'h80);
        rd(11'h7f9, s1);
        idle(2 * SEC_CYC);
        rd(11'h7f9, d);
        chk(d, s1, s1, "halted count");
        chk({7'h0, s1[SEC_HALT_BIT]}, 8'h01, 8'h01, "halt bit");
        host.wr(11'h7f9, 8'h00);
        $display("t_halt done");
    endtask

    // held seconds read: a tick every TICKS cycles flips data line zero
    task automatic t_tone();
        logic [7:0] d;
        int         f;
        logic       o;
        host.wr(11'h7fc, 8'h41);
        host.rd(11'h7f9, 16, d, f, o);
        chk(8'(f), 8'h04, 8'h04, "tone flips");
        host.wr(11'h7fc, 8'h01);
        host.rd(11'h7f9, 16, d, f, o);
        chk(8'(f), 8'h00, 8'h01, "tone off");
        $display("t_tone done");
    endtask

    // supply fail blocks the store and releases the data lines
    task automatic t_fail();
        logic [7:0] d;
        int         f;
        logic       o;
        host.wr(11'h010, 8'ha5);
        pin(sf, 1'b1);
        // blocked byte whose inverse left on the host bus differs from a5
        host.wr(11'h010, 8'h3c);
        host.rd(11'h010, 0, d, f, o);
        chk({7'h0, o}, 8'h00, 8'h00, "released");
        pin(sf, 1'b0);
        rd(11'h010, d);
        chk(d, 8'ha5, 8'ha5, "blocked store");
        pin(health, 1'b0);
        host.wr(11'h7fc, 8'h81);
        rd(11'h7fc, d);
        // whole byte: an undriven bus would still show the host's 7e
        chk(d, 8'h01, 8'h01, "cell flag");
        pin(health, 1'b1);
        $display("t_fail done");
    endtask

    initial begin
        rst_n = 1'b0;
        sf = 1'b0;
        health = 1'b1;
        t_reset();
        t_ram();
        t_cal(8'h03, 8'h01, 8'h03);
        t_cal(8'h04, 8'h29, 8'h02);
        t_freeze();
        t_halt();
        t_tone();
        t_fail();
        t_reset();
        end_sim();
    end

    // the run needs about 3 ms; twice that means a hang
    initial begin
        #6_000_000;
        err_total++;
        end_sim();
    end
endmodule // nvtr_rtc_tb_top

bind nvtr_rtc nvtr_rtc_props u_props (
    .ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .clk_en_in(clk_en_in),
    .addr_in(addr_in), .data_in(data_in), .data_out(data_out),
    .data_oe_out(data_oe_out), .chip_sel_n_in(chip_sel_n_in),
    .out_drive_n_in(out_drive_n_in), .store_n_in(store_n_in),
    .supply_fail_threshold_in(supply_fail_threshold_in),
    .cell_health_flag_in(cell_health_flag_in));
`default_nettype wire
